// ===== rtl/ext_move_pkg.sv
package ext_move_pkg;

  // ----------------------------------------------------------------
  // opcode bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] ESC_PREFIX    = 8'hA5;
  localparam logic [7:0] OPC_LD_BYTE   = 8'h7E;
  localparam logic [7:0] OPC_LD_WORD   = 8'h0B;
  localparam logic [7:0] OPC_ST_DIR    = 8'h7A;
  localparam logic [7:0] OPC_ST_DISP   = 8'h79;
  localparam logic [7:0] OPC_BIT_EXT   = 8'hA9;
  localparam logic [7:0] OPC_TPTR_LD   = 8'h90;
  localparam logic [7:0] OPC_CODE_PC   = 8'h83;
  localparam logic [7:0] OPC_CODE_TP   = 8'h93;

  // ----------------------------------------------------------------
  // sub-codes in the operand bytes
  // ----------------------------------------------------------------
  localparam logic [3:0] SUB_BYTE_DW   = 4'hB;
  localparam logic [3:0] SUB_WORD_DW   = 4'hA;
  localparam logic [3:0] SUB_WORD_WW   = 4'h8;
  localparam logic [3:0] SUB_DWORD_DIR = 4'hD;
  localparam logic [3:0] SUB_ZERO      = 4'h0;
  localparam logic [4:0] SUB_CY_TO_BIT = 5'h12;
  localparam logic [4:0] SUB_BIT_TO_CY = 5'h14;

  // ----------------------------------------------------------------
  // port register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT0_ADDR    = 8'h80;
  localparam logic [7:0] PORT1_ADDR    = 8'h90;
  localparam logic [7:0] PORT2_ADDR    = 8'hA0;
  localparam logic [7:0] PORT3_ADDR    = 8'hB0;

  // ----------------------------------------------------------------
  // state counts in native mode, and the additions
  // ----------------------------------------------------------------
  localparam logic [3:0] CNT_LD_BYTE_DW   = 4'h3;
  localparam logic [3:0] CNT_LD_WORD_DW   = 4'h4;
  localparam logic [3:0] CNT_LD_WORD_WW   = 4'h3;
  localparam logic [3:0] CNT_ST_DWORD_DIR = 4'h6;
  localparam logic [3:0] CNT_ST_WORD_DISP = 4'h7;
  localparam logic [3:0] CNT_CARRY_TO_BIT = 4'h3;
  localparam logic [3:0] CNT_BIT_TO_CARRY = 4'h2;
  localparam logic [3:0] CNT_LOAD_TPTR    = 4'h2;
  localparam logic [3:0] CNT_CODE         = 4'h6;
  localparam logic [3:0] CNT_ONE          = 4'h1;
  localparam logic [3:0] CNT_PREFIX_ADD   = 4'h1;
  localparam logic [3:0] CNT_PORT_ADD     = 4'h1;
  localparam logic [3:0] CNT_PORT_BIT_ADD = 4'h2;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP  = 16'h0001;

  typedef enum logic [3:0] {
    OP_NONE         = 4'h0,
    OP_LD_BYTE_DW   = 4'h1,
    OP_LD_WORD_DW   = 4'h2,
    OP_LD_WORD_WW   = 4'h3,
    OP_ST_DWORD_DIR = 4'h4,
    OP_ST_WORD_DISP = 4'h5,
    OP_CARRY_TO_BIT = 4'h6,
    OP_BIT_TO_CARRY = 4'h7,
    OP_LOAD_TPTR    = 4'h8,
    OP_CODE_PC      = 4'h9,
    OP_CODE_TP      = 4'hA
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_OP     = 3'b000,
    ST_OPND   = 3'b001,
    ST_DECODE = 3'b010,
    ST_EXEC   = 3'b011
  } dec_state_t;

  function automatic logic is_port(input logic [7:0] addr);
    is_port = (addr == PORT0_ADDR) || (addr == PORT1_ADDR) ||
              (addr == PORT2_ADDR) || (addr == PORT3_ADDR);
  endfunction : is_port

endpackage : ext_move_pkg

// ===== rtl/exec_timer.sv
`timescale 1ns/100ps
module exec_timer import ext_move_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [3:0] count,
  output logic            busy,
  output logic            last
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  assign busy    = (cnt_r != SUB_ZERO);
  assign last    = (cnt_r == CNT_ONE);
  assign cnt_nxt = start ? count : (busy ? cnt_r - CNT_ONE : cnt_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_r <= SUB_ZERO;
    else     cnt_r <= cnt_nxt;
  end

  a_exec_three: assert property (@(posedge clk) disable iff (rst)
    (start && count == 4'h3) |=> busy [*3] ##1 !busy)
    else $error("three-state execution has wrong length");

  a_exec_five: assert property (@(posedge clk) disable iff (rst)
    (start && count == 4'h5) |=> busy [*5] ##1 !busy)
    else $error("five-state execution has wrong length");

endmodule : exec_timer

// ===== rtl/addr_adder.sv
`timescale 1ns/100ps
module addr_adder (
  input  wire logic [23:0] base,
  input  wire logic [15:0] offset,
  output logic      [23:0] sum
);

  assign sum = base + {8'h00, offset};

endmodule : addr_adder

// ===== rtl/extended_move_decode.sv
// Summary of operation
// - In compatibility mode the extended moves need the escape prefix, in native mode not.
// - Byte load through a dword pointer: 7E, ptr/B, dst/0; four or three states.
// - Word load through a dword pointer: 0B, ptr/A, dst/0; five or four states.
// - Word load through a word pointer: 0B, ptr/8, dst/0.
// - Dword store to an 8-bit direct address: 7A, reg/D, address; seven or six states.
// - Word store at dword pointer plus displacement: 79, ptr/src, disp high, disp low.
// - A bit move copies source bit to destination bit with the carry as one operand.
// - A bit move changes only its destination bit, or only the carry.
// - A carry-to-bit move into a port register adds two states.
// - A bit-to-carry move or direct store to a port register adds one state.
// - Carry-to-bit store decodes A9, 1001 0yyy, address; four or three bytes.
// - The pointer load puts the high constant byte high and the low byte low.
// - The pointer load is 90, high, low; three bytes, two states, no flags.
// - The code lookup reads program memory at accumulator plus 16-bit base.
// - With the program counter as base, it first advances to the next instruction.
// - With the table pointer as base, the pointer is left unchanged.
`timescale 1ns/100ps
module extended_move_decode import ext_move_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        native_mode,
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  fetch_byte,
  output logic             fetch_ready,
  input  wire logic [7:0]  acc_value,
  input  wire logic [31:0] ptr_value,
  input  wire logic        bit_rd_data,
  input  wire logic [7:0]  code_data,
  output logic [15:0]      program_counter,
  output logic [3:0]       ptr_index,
  output logic             op_done,
  output op_kind_t         op_kind,
  output logic [3:0]       op_dst_idx,
  output logic [3:0]       op_src_idx,
  output logic [23:0]      op_addr,
  output logic [7:0]       bit_addr,
  output logic [2:0]       bit_pos,
  output logic             bit_wr_en,
  output logic             bit_wr_data,
  output logic             carry_flag,
  output logic             code_rd,
  output logic [15:0]      code_addr,
  output logic             acc_wr_en,
  output logic [7:0]       acc_wr_data,
  output logic [7:0]       table_pointer_high,
  output logic [7:0]       table_pointer_low,
  output logic             illegal_op
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] operand_len(input logic [7:0] opc);
    case (opc)
      OPC_ST_DISP: operand_len = 2'd3;
      OPC_LD_BYTE, OPC_LD_WORD, OPC_ST_DIR, OPC_BIT_EXT, OPC_TPTR_LD: operand_len = 2'd2;
      default:     operand_len = 2'd0;
    endcase
  endfunction : operand_len

  function automatic op_kind_t decode_kind(input logic [7:0] opc, input logic [7:0] b1,
                                           input logic [7:0] b2, input logic ext_ok,
                                           input logic plain_ok);
    decode_kind = OP_NONE;
    if (ext_ok) begin
      case (opc)
        OPC_LD_BYTE: if (b1[3:0] == SUB_BYTE_DW && b2[3:0] == SUB_ZERO) decode_kind = OP_LD_BYTE_DW;
        OPC_LD_WORD: begin
          if (b1[3:0] == SUB_WORD_DW && b2[3:0] == SUB_ZERO) decode_kind = OP_LD_WORD_DW;
          if (b1[3:0] == SUB_WORD_WW && b2[3:0] == SUB_ZERO) decode_kind = OP_LD_WORD_WW;
        end
        OPC_ST_DIR:  if (b1[3:0] == SUB_DWORD_DIR) decode_kind = OP_ST_DWORD_DIR;
        OPC_ST_DISP: decode_kind = OP_ST_WORD_DISP;
        OPC_BIT_EXT: begin
          if (b1[7:3] == SUB_CY_TO_BIT) decode_kind = OP_CARRY_TO_BIT;
          if (b1[7:3] == SUB_BIT_TO_CY) decode_kind = OP_BIT_TO_CARRY;
        end
        default: decode_kind = OP_NONE;
      endcase
    end
    if (plain_ok) begin
      case (opc)
        OPC_TPTR_LD: decode_kind = OP_LOAD_TPTR;
        OPC_CODE_PC: decode_kind = OP_CODE_PC;
        OPC_CODE_TP: decode_kind = OP_CODE_TP;
        default:     ;
      endcase
    end
  endfunction : decode_kind

  function automatic logic [3:0] state_count(input op_kind_t k, input logic compat,
                                             input logic port);
    logic [3:0] pre;
    pre = compat ? CNT_PREFIX_ADD : SUB_ZERO;
    case (k)
      OP_LD_BYTE_DW:   state_count = CNT_LD_BYTE_DW + pre;
      OP_LD_WORD_DW:   state_count = CNT_LD_WORD_DW + pre;
      OP_LD_WORD_WW:   state_count = CNT_LD_WORD_WW + pre;
      OP_ST_DWORD_DIR: state_count = CNT_ST_DWORD_DIR + pre + (port ? CNT_PORT_ADD : SUB_ZERO);
      OP_ST_WORD_DISP: state_count = CNT_ST_WORD_DISP + pre;
      OP_CARRY_TO_BIT: state_count = CNT_CARRY_TO_BIT + pre + (port ? CNT_PORT_BIT_ADD : SUB_ZERO);
      OP_BIT_TO_CARRY: state_count = CNT_BIT_TO_CARRY + pre + (port ? CNT_PORT_ADD : SUB_ZERO);
      OP_LOAD_TPTR:    state_count = CNT_LOAD_TPTR;
      OP_CODE_PC,
      OP_CODE_TP:      state_count = CNT_CODE;
      default:         state_count = SUB_ZERO;
    endcase
  endfunction : state_count

  // ----------------------------------------------------------------
  // state and byte capture
  // ----------------------------------------------------------------
  dec_state_t      state_r, state_nxt;
  logic [7:0]      opc_r;
  logic [2:0][7:0] opnd_r;
  logic [1:0]      idx_r, need_r;
  logic            esc_r, first_r;
  logic [15:0]     pc_r, tp_r;
  logic            carry_r;
  op_kind_t        kind_w;
  logic [3:0]      count_w;
  logic            accept, ext_ok, plain_ok, port_w, start_w, t_busy, t_last;
  logic [23:0]     base_w, sum_w;
  logic [15:0]     off_w;

  assign accept   = fetch_valid && fetch_ready;
  assign fetch_ready = (state_r == ST_OP || state_r == ST_OPND);
  assign ext_ok   = native_mode ? !esc_r : esc_r;
  assign plain_ok = !esc_r;
  assign port_w   = is_port(opnd_r[1]);
  assign kind_w   = decode_kind(opc_r, opnd_r[0], opnd_r[1], ext_ok, plain_ok);
  assign count_w  = state_count(kind_w, !native_mode, port_w);
  assign start_w  = (state_r == ST_DECODE) && (kind_w != OP_NONE);
  assign ptr_index = opnd_r[0][7:4];
  assign program_counter = pc_r;
  assign carry_flag = carry_r;
  assign table_pointer_high = tp_r[15:8];
  assign table_pointer_low  = tp_r[7:0];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OP:     if (accept && !(fetch_byte == ESC_PREFIX && !esc_r))
                   state_nxt = (operand_len(fetch_byte) == 2'd0) ? ST_DECODE : ST_OPND;
      ST_OPND:   if (accept && (idx_r + 2'd1) == need_r) state_nxt = ST_DECODE;
      ST_DECODE: state_nxt = start_w ? ST_EXEC : ST_OP;
      ST_EXEC:   if (t_last) state_nxt = ST_OP;
      default:   state_nxt = ST_OP;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_OP;
      esc_r   <= 1'b0;
      opc_r   <= 8'h00;
      opnd_r  <= '0;
      idx_r   <= 2'd0;
      need_r  <= 2'd0;
      pc_r    <= PC_RESET;
    end else begin
      state_r <= state_nxt;
      if (accept) pc_r <= pc_r + PC_STEP;
      if (accept && state_r == ST_OP) begin
        if (fetch_byte == ESC_PREFIX && !esc_r) begin
          esc_r <= 1'b1;
        end else begin
          opc_r  <= fetch_byte;
          need_r <= operand_len(fetch_byte);
          idx_r  <= 2'd0;
        end
      end
      if (accept && state_r == ST_OPND) begin
        opnd_r[idx_r] <= fetch_byte;
        idx_r         <= idx_r + 2'd1;
      end
      if (state_nxt == ST_OP && state_r != ST_OP) esc_r <= 1'b0;
    end
  end

  exec_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (start_w),
    .count (count_w),
    .busy  (t_busy),
    .last  (t_last)
  );

  // ----------------------------------------------------------------
  // address forming
  // ----------------------------------------------------------------
  always_comb begin
    case (op_kind)
      OP_LD_WORD_WW:   base_w = {8'h00, ptr_value[15:0]};
      OP_ST_DWORD_DIR: base_w = 24'h000000;
      OP_CODE_PC:      base_w = {8'h00, pc_r};
      OP_CODE_TP:      base_w = {8'h00, tp_r};
      default:         base_w = ptr_value[23:0];
    endcase
    case (op_kind)
      OP_ST_WORD_DISP: off_w = {opnd_r[1], opnd_r[2]};
      OP_ST_DWORD_DIR: off_w = {8'h00, opnd_r[1]};
      OP_CODE_PC,
      OP_CODE_TP:      off_w = {8'h00, acc_value};
      default:         off_w = 16'h0000;
    endcase
  end

  addr_adder u_adder (
    .base   (base_w),
    .offset (off_w),
    .sum    (sum_w)
  );

  // ----------------------------------------------------------------
  // execution effects
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_kind     <= OP_NONE;
      op_dst_idx  <= 4'h0;
      op_src_idx  <= 4'h0;
      op_addr     <= 24'h000000;
      bit_addr    <= 8'h00;
      bit_pos     <= 3'h0;
      first_r     <= 1'b0;
      code_rd     <= 1'b0;
      code_addr   <= 16'h0000;
      illegal_op  <= 1'b0;
    end else begin
      first_r    <= start_w;
      code_rd    <= 1'b0;
      illegal_op <= (state_r == ST_DECODE) && !start_w;
      if (start_w) begin
        op_kind    <= kind_w;
        op_dst_idx <= opnd_r[1][7:4];
        op_src_idx <= (kind_w == OP_ST_WORD_DISP) ? opnd_r[0][3:0] : opnd_r[0][7:4];
        bit_addr   <= opnd_r[1];
        bit_pos    <= opnd_r[0][2:0];
      end
      if (first_r) begin
        op_addr   <= sum_w;
        code_addr <= sum_w[15:0];
        code_rd   <= (op_kind == OP_CODE_PC) || (op_kind == OP_CODE_TP);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_done     <= 1'b0;
      bit_wr_en   <= 1'b0;
      bit_wr_data <= 1'b0;
      acc_wr_en   <= 1'b0;
      acc_wr_data <= 8'h00;
      carry_r     <= 1'b0;
      tp_r        <= 16'h0000;
    end else begin
      op_done   <= t_last;
      bit_wr_en <= t_last && op_kind == OP_CARRY_TO_BIT;
      acc_wr_en <= t_last && (op_kind == OP_CODE_PC || op_kind == OP_CODE_TP);
      if (t_last) begin
        bit_wr_data <= carry_r;
        acc_wr_data <= code_data;
        if (op_kind == OP_BIT_TO_CARRY) carry_r <= bit_rd_data;
        if (op_kind == OP_LOAD_TPTR) tp_r <= {opnd_r[0], opnd_r[1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_prefix_needed: assert property (start_w && !native_mode && kind_w inside
    {OP_LD_BYTE_DW, OP_ST_DWORD_DIR, OP_CARRY_TO_BIT} |-> esc_r)
    else $error("extended move decoded without escape in compatibility mode");

  a_stall_fetch: assert property (t_busy |-> !fetch_ready)
    else $error("fetch accepted during execution stall");

  a_dir_port_add: assert property (start_w && kind_w == OP_ST_DWORD_DIR
    |-> count_w == (port_w ? 4'h7 : 4'h6) + (native_mode ? 4'h0 : 4'h1))
    else $error("direct store state count wrong");

  a_bit_port_add: assert property (start_w && kind_w == OP_CARRY_TO_BIT
    |-> count_w == (port_w ? 4'h5 : 4'h3) + (native_mode ? 4'h0 : 4'h1))
    else $error("carry-to-bit state count wrong");

  a_tptr_two: assert property (start_w && kind_w == OP_LOAD_TPTR
    |=> t_busy [*2] ##1 (!t_busy && tp_r == {$past(opnd_r[0], 3), $past(opnd_r[1], 3)}))
    else $error("pointer load timing or bytes wrong");

  a_tptr_kept: assert property ((t_busy && op_kind == OP_CODE_TP) |=> $stable(tp_r))
    else $error("table pointer altered by lookup");

  a_code_pc_base: assert property (code_rd && op_kind == OP_CODE_PC
    |-> code_addr == $past(pc_r) + {8'h00, $past(acc_value)})
    else $error("lookup address not next pc plus accumulator");

  a_bit_only_dst: assert property (bit_wr_en |-> $stable(carry_r) && $stable(tp_r))
    else $error("bit store changed another register");

  a_bit_to_carry: assert property (t_last && op_kind == OP_BIT_TO_CARRY
    |=> carry_r == $past(bit_rd_data) && !bit_wr_en)
    else $error("bit-to-carry move wrong");

endmodule : extended_move_decode

// ===== sim/tb.sv
`timescale 1ns/100ps
module tb import ext_move_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk, rst, native_mode, fetch_valid, bit_rd_data;
  logic [7:0]  fetch_byte, acc_value, code_data;
  logic [31:0] ptr_value;
  logic        fetch_ready, op_done, bit_wr_en, bit_wr_data, carry_flag;
  logic        code_rd, acc_wr_en, illegal_op;
  logic [15:0] program_counter, code_addr;
  logic [3:0]  ptr_index, op_dst_idx, op_src_idx;
  logic [23:0] op_addr;
  logic [7:0]  bit_addr, acc_wr_data, table_pointer_high, table_pointer_low;
  logic [2:0]  bit_pos;
  op_kind_t    op_kind;
  int          errors, comparisons, sent, cyc, rd_seen, ill_seen;

  typedef struct packed {
    logic nat; logic [2:0] n; logic [39:0] b; op_kind_t kind; logic [3:0] st;
    logic ic; logic [3:0] dst; logic [3:0] src; logic ac; logic [23:0] adr;
  } row_t;

  // nat, bytes, kind, native-or-compat states, index check, address check
  localparam row_t ROWS [22] = '{
    '{1'h1, 3'h3, 40'h7E5B200000, OP_LD_BYTE_DW,   4'h3, 1'h1, 4'h2, 4'h5, 1'h1, 24'h11F000},
    '{1'h0, 3'h4, 40'hA57E5B2000, OP_LD_BYTE_DW,   4'h4, 1'h1, 4'h2, 4'h5, 1'h1, 24'h11F000},
    '{1'h1, 3'h3, 40'h0B3A400000, OP_LD_WORD_DW,   4'h4, 1'h1, 4'h4, 4'h3, 1'h1, 24'h11F000},
    '{1'h0, 3'h4, 40'hA50B3A4000, OP_LD_WORD_DW,   4'h5, 1'h1, 4'h4, 4'h3, 1'h1, 24'h11F000},
    '{1'h1, 3'h3, 40'h0B68100000, OP_LD_WORD_WW,   4'h3, 1'h1, 4'h1, 4'h6, 1'h1, 24'h00F000},
    '{1'h0, 3'h4, 40'hA50B681000, OP_LD_WORD_WW,   4'h4, 1'h1, 4'h1, 4'h6, 1'h1, 24'h00F000},
    '{1'h1, 3'h3, 40'h7A4D300000, OP_ST_DWORD_DIR, 4'h6, 1'h0, 4'h0, 4'h0, 1'h1, 24'h000030},
    '{1'h1, 3'h3, 40'h7A4D800000, OP_ST_DWORD_DIR, 4'h7, 1'h0, 4'h0, 4'h0, 1'h1, 24'h000080},
    '{1'h1, 3'h3, 40'h7A4D810000, OP_ST_DWORD_DIR, 4'h6, 1'h0, 4'h0, 4'h0, 1'h1, 24'h000081},
    '{1'h0, 3'h4, 40'hA57A4DB000, OP_ST_DWORD_DIR, 4'h8, 1'h0, 4'h0, 4'h0, 1'h1, 24'h0000B0},
    '{1'h1, 3'h4, 40'h7952234500, OP_ST_WORD_DISP, 4'h7, 1'h0, 4'h0, 4'h0, 1'h1, 24'h121345},
    '{1'h0, 3'h5, 40'hA579522345, OP_ST_WORD_DISP, 4'h8, 1'h0, 4'h0, 4'h0, 1'h1, 24'h121345},
    '{1'h1, 3'h3, 40'hA993200000, OP_CARRY_TO_BIT, 4'h3, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h1, 3'h3, 40'hA995900000, OP_CARRY_TO_BIT, 4'h5, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h0, 3'h4, 40'hA5A993B000, OP_CARRY_TO_BIT, 4'h6, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h1, 3'h3, 40'hA9A1200000, OP_BIT_TO_CARRY, 4'h2, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h1, 3'h3, 40'hA9A1A00000, OP_BIT_TO_CARRY, 4'h3, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h0, 3'h4, 40'hA5A9A18000, OP_BIT_TO_CARRY, 4'h4, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h1, 3'h3, 40'h9012340000, OP_LOAD_TPTR,    4'h2, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h0, 3'h3, 40'h90ABCD0000, OP_LOAD_TPTR,    4'h2, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h1, 3'h1, 40'h8300000000, OP_CODE_PC,      4'h6, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000},
    '{1'h0, 3'h1, 40'h9300000000, OP_CODE_TP,      4'h6, 1'h0, 4'h0, 4'h0, 1'h0, 24'h000000}
  };

  extended_move_decode dut_u (
    .clk(clk), .rst(rst), .native_mode(native_mode), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .fetch_ready(fetch_ready), .acc_value(acc_value),
    .ptr_value(ptr_value), .bit_rd_data(bit_rd_data), .code_data(code_data),
    .program_counter(program_counter), .ptr_index(ptr_index), .op_done(op_done),
    .op_kind(op_kind), .op_dst_idx(op_dst_idx), .op_src_idx(op_src_idx),
    .op_addr(op_addr), .bit_addr(bit_addr), .bit_pos(bit_pos), .bit_wr_en(bit_wr_en),
    .bit_wr_data(bit_wr_data), .carry_flag(carry_flag), .code_rd(code_rd),
    .code_addr(code_addr), .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data),
    .table_pointer_high(table_pointer_high), .table_pointer_low(table_pointer_low),
    .illegal_op(illegal_op)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check_val(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0s expected %h seen %h", nm, exp, seen);
    end
  endtask : check_val

  task report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // offers n bytes back to back, then counts cycles up to op_done
  task automatic run(input logic nat, input int n, input logic [39:0] b);
    int k;
    @(posedge clk);
    native_mode <= nat;
    for (int i = 0; i < n; i++) begin
      fetch_valid <= 1'h1;
      fetch_byte  <= b[39-8*i -: 8];
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (fetch_ready !== 1'h1 && k < 50);
      @(posedge clk);
      sent++;
    end
    fetch_valid <= 1'h0;
    cyc = 0;
    rd_seen = 0;
    ill_seen = 0;
    do begin
      @(negedge clk);
      cyc++;
      if (code_rd === 1'h1) rd_seen++;
      if (illegal_op === 1'h1) ill_seen++;
    end while (op_done !== 1'h1 && cyc < 40);
  endtask : run

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 4000);
    errors++;
    $display("Error watchdog expected finish seen hang");
    report_and_stop();
  end

  initial begin
    rst = 1'h1; native_mode = 1'h1; fetch_valid = 1'h0; fetch_byte = 8'h00;
    acc_value = 8'hFF; ptr_value = 32'hAB11F000; bit_rd_data = 1'h0; code_data = 8'h5A;
    errors = 0; comparisons = 0; sent = 0;
    repeat (10) @(posedge clk);
    check_val("ready in reset", fetch_ready, 1);
    check_val("pc in reset", program_counter, 0);
    check_val("carry in reset", carry_flag, 0);
    rst <= 1'h0;
    $display("test reset done");
    for (int r = 0; r < 22; r++) begin
      run(ROWS[r].nat, ROWS[r].n, ROWS[r].b);
      check_val("states", cyc, ROWS[r].st + 2);
      check_val("op_kind", op_kind, ROWS[r].kind);
      if (ROWS[r].ic) check_val("dst", op_dst_idx, ROWS[r].dst);
      if (ROWS[r].ic) check_val("src", op_src_idx, ROWS[r].src);
      if (ROWS[r].ac) check_val("op_addr", op_addr, ROWS[r].adr);
      if (ROWS[r].ic) check_val("ptr_index", ptr_index, ROWS[r].src);
      check_val("code_rd", rd_seen, ROWS[r].kind inside {OP_CODE_PC, OP_CODE_TP});
      check_val("no illegal", ill_seen, 0);
      check_val("carry", carry_flag, 0);
      check_val("pc", program_counter, sent);
    end
    $display("test decode table done");
    @(posedge clk);
    bit_rd_data <= 1'h1;
    run(1'h1, 3, 40'hA9A5200000);
    check_val("carry set", carry_flag, 1);
    check_val("bit_addr", bit_addr, 8'h20);
    check_val("bit_pos", bit_pos, 3'h5);
    @(posedge clk);
    bit_rd_data <= 1'h0;
    run(1'h1, 3, 40'h7E5B200000);
    check_val("carry kept", carry_flag, 1);
    run(1'h1, 3, 40'hA993800000);
    check_val("bit_wr_en", bit_wr_en, 1);
    check_val("bit_wr_data", bit_wr_data, 1);
    check_val("bit_pos wr", {bit_addr, 5'h00, bit_pos}, 16'h8003);
    check_val("carry after store", carry_flag, 1);
    run(1'h1, 3, 40'hA9A1300000);
    check_val("carry clear", carry_flag, 0);
    $display("test bit moves done");
    run(1'h1, 3, 40'h90FFF00000);
    check_val("tp high", table_pointer_high, 8'hFF);
    check_val("tp low", table_pointer_low, 8'hF0);
    check_val("carry tp", carry_flag, 0);
    run(1'h1, 1, 40'h9300000000);
    check_val("code_addr tp", code_addr, 16'h00EF);
    check_val("code_rd", rd_seen, 1);
    check_val("acc_wr_en", acc_wr_en, 1);
    check_val("acc_wr_data", acc_wr_data, 8'h5A);
    check_val("tp kept", {table_pointer_high, table_pointer_low}, 16'hFFF0);
    run(1'h0, 1, 40'h8300000000);
    check_val("code_addr pc", code_addr, sent[15:0] + 16'h00FF);
    check_val("acc pc", acc_wr_data, 8'h5A);
    $display("test table lookup done");
    run(1'h0, 1, 40'h0000000000);
    check_val("illegal", ill_seen, 1);
    check_val("no done", op_done, 0);
    $display("test unknown opcode done");
    @(posedge clk);
    fetch_valid <= 1'h1;
    fetch_byte  <= 8'h83;
    @(posedge clk);
    fetch_valid <= 1'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h1;
    #2;
    check_val("pc mid reset", program_counter, 0);
    check_val("ready mid reset", fetch_ready, 1);
    check_val("done mid reset", op_done, 0);
    check_val("tp mid reset", {table_pointer_high, table_pointer_low}, 16'h0000);
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    sent = 0;
    run(1'h1, 3, 40'h7E5B200000);
    check_val("states after reset", cyc, 5);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : tb
